// *** rtl/aspm_pkg.sv ***
package aspm_pkg;

    // Register addresses on the special-function port
    localparam logic [7:0] CTRL_ADDR = 8'h98;
    localparam logic [7:0] DATA_ADDR = 8'h99;

    // Control register field positions
    localparam int MODE_POS  = 7;
    localparam int FIXED_POS = 6;
    localparam int MCE_POS   = 5;
    localparam int REN_POS   = 4;
    localparam int TB8_POS   = 3;
    localparam int RB8_POS   = 2;
    localparam int TI_POS    = 1;
    localparam int RI_POS    = 0;

    // Values after reset
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET  = 8'h00;

    // Counts
    localparam logic [7:0] TIMER_TOP  = 8'hff;
    localparam logic [2:0] LAST_DATA  = 3'h7;
    localparam int         BUF_DEPTH  = 2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_NINTH,
        ST_STOP
    } aspm_state_type;

endpackage

// *** rtl/aspm_uart.sv ***
`timescale 1ns/10ps
`default_nettype none

module aspm_uart (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Special-function register port
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic       i_sfr_bit_wr,
    input  wire logic [2:0] i_sfr_bit_sel,
    input  wire logic [7:0] i_sfr_wdata,
    input  wire logic       i_sfr_rd,
    output logic      [7:0] o_sfr_rdata,
    output logic            o_tx_ready,
    // Baud timer
    input  wire logic       i_timer_en,
    input  wire logic       i_timer_tick,
    input  wire logic       i_tx_ovf,
    input  wire logic [7:0] i_baud_reload,
    // Interrupt
    input  wire logic       i_int_en,
    output logic            o_irq,
    // Serial lines
    input  wire logic       i_serial_rx_line,
    output logic            o_serial_tx_line
);

    // Control register fields
    logic       mode_q, mce_q, ren_q, tb8_q, rb8_q, ti_q, ri_q;
    logic [7:0] rbuf_q;
    logic [7:0] ctrl_img;

    // Image of the control register as software sees it
    always_comb begin
        ctrl_img = {mode_q, 1'b1, mce_q, ren_q,
                    tb8_q, rb8_q, ti_q, ri_q};
    end

    // Register write decoding, used for every field
    function automatic logic wr_bit(input logic cur, input int pos,
                                    input logic [7:0] a, input logic wr,
                                    input logic bw, input logic [2:0] sel,
                                    input logic [7:0] d);
        logic r;
        r = cur;
        if (a == aspm_pkg::CTRL_ADDR && wr) begin
            r = d[pos];
        end else if (a == aspm_pkg::CTRL_ADDR && bw && sel == 3'(pos)) begin
            r = d[0];
        end
        return r;
    endfunction

    logic ctrl_wr_any;
    logic data_wr;
    assign ctrl_wr_any = (i_sfr_addr == aspm_pkg::CTRL_ADDR)
                       && (i_sfr_wr || i_sfr_bit_wr);
    assign data_wr     = (i_sfr_addr == aspm_pkg::DATA_ADDR) && i_sfr_wr;

    // Software-owned control fields, byte or single-bit writes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_q <= aspm_pkg::CTRL_RESET[aspm_pkg::MODE_POS];
            mce_q  <= aspm_pkg::CTRL_RESET[aspm_pkg::MCE_POS];
            ren_q  <= aspm_pkg::CTRL_RESET[aspm_pkg::REN_POS];
            tb8_q  <= aspm_pkg::CTRL_RESET[aspm_pkg::TB8_POS];
        end else begin
            mode_q <= wr_bit(mode_q, aspm_pkg::MODE_POS, i_sfr_addr,
                             i_sfr_wr, i_sfr_bit_wr, i_sfr_bit_sel,
                             i_sfr_wdata);
            mce_q  <= wr_bit(mce_q, aspm_pkg::MCE_POS, i_sfr_addr,
                             i_sfr_wr, i_sfr_bit_wr, i_sfr_bit_sel,
                             i_sfr_wdata);
            ren_q  <= wr_bit(ren_q, aspm_pkg::REN_POS, i_sfr_addr,
                             i_sfr_wr, i_sfr_bit_wr, i_sfr_bit_sel,
                             i_sfr_wdata);
            tb8_q  <= wr_bit(tb8_q, aspm_pkg::TB8_POS, i_sfr_addr,
                             i_sfr_wr, i_sfr_bit_wr, i_sfr_bit_sel,
                             i_sfr_wdata);
        end
    end

    // Read data is registered; the transmit side is never visible
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sfr_rdata <= aspm_pkg::DATA_RESET;
        end else if (i_sfr_rd) begin
            if (i_sfr_addr == aspm_pkg::CTRL_ADDR) begin
                o_sfr_rdata <= ctrl_img;
            end else if (i_sfr_addr == aspm_pkg::DATA_ADDR) begin
                o_sfr_rdata <= rbuf_q;
            end else begin
                o_sfr_rdata <= aspm_pkg::DATA_RESET;
            end
        end
    end

    // Request follows the flags while i_int_en is high; then cleared only when software clears them
    assign o_irq = i_int_en && (ti_q || ri_q);

    // Two-entry transmit buffer so a back-to-back write is not lost
    logic [7:0] fifo_mem_q [aspm_pkg::BUF_DEPTH];
    logic       wr_ptr_q, rd_ptr_q;
    logic [1:0] fifo_cnt_q;
    logic       fifo_valid, fifo_pop, fifo_push;
    assign o_tx_ready = (fifo_cnt_q != 2'(aspm_pkg::BUF_DEPTH));
    assign fifo_valid = (fifo_cnt_q != 2'h0);
    assign fifo_push  = data_wr && o_tx_ready;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr_q   <= 1'b0;
            rd_ptr_q   <= 1'b0;
            fifo_cnt_q <= 2'h0;
        end else begin
            if (fifo_push) begin
                fifo_mem_q[wr_ptr_q] <= i_sfr_wdata;
                wr_ptr_q             <= ~wr_ptr_q;
            end
            if (fifo_pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            fifo_cnt_q <= fifo_cnt_q + 2'(fifo_push) - 2'(fifo_pop);
        end
    end

    // Transmit bit tick: every second overflow of the external timer
    logic tx_half_q, tx_tick;
    assign tx_tick = i_tx_ovf && tx_half_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_half_q <= 1'b0;
        end else if (i_tx_ovf) begin
            tx_half_q <= ~tx_half_q;
        end
    end

    // Transmit sequencer; a frame only starts on a bit boundary
    aspm_pkg::aspm_state_type tx_st_q;
    logic [7:0] tx_sh_q;
    logic [2:0] tx_cnt_q;
    logic       tx_nine_q;
    logic       ti_set;
    assign fifo_pop = tx_tick && (tx_st_q == aspm_pkg::ST_IDLE)
                    && fifo_valid;
    assign ti_set   = tx_tick && (tx_st_q == aspm_pkg::ST_NINTH
                    || (tx_st_q == aspm_pkg::ST_DATA && tx_cnt_q ==
                        aspm_pkg::LAST_DATA && !mode_q));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_st_q          <= aspm_pkg::ST_IDLE;
            tx_sh_q          <= aspm_pkg::DATA_RESET;
            tx_cnt_q         <= 3'h0;
            tx_nine_q        <= 1'b0;
            o_serial_tx_line <= 1'b1;
        end else if (tx_tick) begin
            case (tx_st_q)
                aspm_pkg::ST_IDLE: begin
                    if (fifo_valid) begin
                        tx_sh_q          <= fifo_mem_q[rd_ptr_q];
                        tx_nine_q        <= tb8_q;
                        o_serial_tx_line <= 1'b0;
                        tx_st_q          <= aspm_pkg::ST_START;
                    end
                end
                aspm_pkg::ST_START: begin
                    o_serial_tx_line <= tx_sh_q[0];
                    tx_sh_q          <= {1'b0, tx_sh_q[7:1]};
                    tx_cnt_q         <= 3'h0;
                    tx_st_q          <= aspm_pkg::ST_DATA;
                end
                aspm_pkg::ST_DATA: begin
                    if (tx_cnt_q != aspm_pkg::LAST_DATA) begin
                        o_serial_tx_line <= tx_sh_q[0];
                        tx_sh_q          <= {1'b0, tx_sh_q[7:1]};
                        tx_cnt_q         <= tx_cnt_q + 3'h1;
                    end else if (mode_q) begin
                        o_serial_tx_line <= tx_nine_q;
                        tx_st_q          <= aspm_pkg::ST_NINTH;
                    end else begin
                        o_serial_tx_line <= 1'b1;
                        tx_st_q          <= aspm_pkg::ST_STOP;
                    end
                end
                aspm_pkg::ST_NINTH: begin
                    o_serial_tx_line <= 1'b1;
                    tx_st_q          <= aspm_pkg::ST_STOP;
                end
                aspm_pkg::ST_STOP: begin
                    tx_st_q <= aspm_pkg::ST_IDLE;
                end
                default: begin
                    tx_st_q          <= aspm_pkg::ST_IDLE;
                    o_serial_tx_line <= 1'b1;
                end
            endcase
        end
    end

    // Receive line passes two flops before anything looks at it
    logic rx_m_q, rx_s_q, rx_prev_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_m_q    <= 1'b1;
            rx_s_q    <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rx_m_q    <= i_serial_rx_line;
            rx_s_q    <= rx_m_q;
            rx_prev_q <= rx_s_q;
        end
    end

    // Private receive timer; forced reload aligns it to the start edge
    aspm_pkg::aspm_state_type rx_st_q;
    logic [7:0] rx_tmr_q;
    logic       rx_ph_q, rx_ovf, rx_samp, rx_fall;
    assign rx_fall = rx_prev_q && !rx_s_q && ren_q
                   && (rx_st_q == aspm_pkg::ST_IDLE);
    assign rx_ovf  = i_timer_en && i_timer_tick
                   && (rx_tmr_q == aspm_pkg::TIMER_TOP);
    assign rx_samp = rx_ovf && !rx_ph_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_tmr_q <= aspm_pkg::CNT_RESET;
            rx_ph_q  <= 1'b0;
        end else if (rx_fall) begin
            rx_tmr_q <= i_baud_reload;
            rx_ph_q  <= 1'b0;
        end else if (i_timer_en && i_timer_tick) begin
            rx_tmr_q <= rx_ovf ? i_baud_reload : rx_tmr_q + 8'h01;
            if (rx_ovf) begin
                rx_ph_q <= ~rx_ph_q;
            end
        end
    end

    // Receive sequencer and acceptance test
    logic [7:0] rx_sh_q;
    logic [2:0] rx_cnt_q;
    logic       rx_nine_q, rx_accept, ri_set;
    assign rx_accept = !ri_q && (!mce_q
                     || (mode_q ? rx_nine_q : rx_s_q));
    assign ri_set    = rx_samp && (rx_st_q == aspm_pkg::ST_STOP)
                     && rx_accept;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_st_q   <= aspm_pkg::ST_IDLE;
            rx_sh_q   <= aspm_pkg::DATA_RESET;
            rx_cnt_q  <= 3'h0;
            rx_nine_q <= 1'b0;
            rbuf_q    <= aspm_pkg::DATA_RESET;
            rb8_q     <= aspm_pkg::CTRL_RESET[aspm_pkg::RB8_POS];
        end else begin
            // Software write first; a latching frame below still wins,
            // so a write is lost to a frame latched in the same cycle
            rb8_q <= wr_bit(rb8_q, aspm_pkg::RB8_POS, i_sfr_addr,
                            i_sfr_wr, i_sfr_bit_wr, i_sfr_bit_sel,
                            i_sfr_wdata);
            if (rx_fall) begin
                rx_st_q <= aspm_pkg::ST_START;
            end else if (rx_samp) begin
                case (rx_st_q)
                    aspm_pkg::ST_START: begin
                        // A glitch shorter than half a bit is dropped
                        rx_cnt_q <= 3'h0;
                        rx_st_q  <= rx_s_q ? aspm_pkg::ST_IDLE
                                           : aspm_pkg::ST_DATA;
                    end
                    aspm_pkg::ST_DATA: begin
                        rx_sh_q  <= {rx_s_q, rx_sh_q[7:1]};
                        rx_cnt_q <= rx_cnt_q + 3'h1;
                        if (rx_cnt_q == aspm_pkg::LAST_DATA) begin
                            rx_st_q <= mode_q ? aspm_pkg::ST_NINTH
                                              : aspm_pkg::ST_STOP;
                        end
                    end
                    aspm_pkg::ST_NINTH: begin
                        rx_nine_q <= rx_s_q;
                        rx_st_q   <= aspm_pkg::ST_STOP;
                    end
                    aspm_pkg::ST_STOP: begin
                        // Rejected or overrun frames leave the latch alone
                        if (rx_accept) begin
                            rbuf_q <= rx_sh_q;
                            rb8_q  <= mode_q ? rx_nine_q : rx_s_q;
                        end
                        rx_st_q <= aspm_pkg::ST_IDLE;
                    end
                    default: begin
                        rx_st_q <= aspm_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ti_q <= aspm_pkg::CTRL_RESET[aspm_pkg::TI_POS];
            ri_q <= aspm_pkg::CTRL_RESET[aspm_pkg::RI_POS];
        end else begin
            ti_q <= ti_set || wr_bit(ti_q, aspm_pkg::TI_POS, i_sfr_addr,
                    i_sfr_wr, i_sfr_bit_wr, i_sfr_bit_sel,
                    i_sfr_wdata);
            ri_q <= ri_set || wr_bit(ri_q, aspm_pkg::RI_POS, i_sfr_addr,
                    i_sfr_wr, i_sfr_bit_wr, i_sfr_bit_sel,
                    i_sfr_wdata);
        end
    end

    // Checks on the block's own behaviour
    ninth_needs_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
        tx_st_q == aspm_pkg::ST_NINTH |-> mode_q)
        else $error("ninth bit sent in 8-bit mode");
    start_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
        tx_st_q == aspm_pkg::ST_START |-> !o_serial_tx_line)
        else $error("start bit not low");
    write_launch_a: assert property (@(posedge i_clk) disable iff (i_rst)
        data_wr && fifo_cnt_q == 2'h0 && !fifo_pop |=> fifo_valid)
        else $error("data write did not queue a frame");
    ti_at_stop_a: assert property (@(posedge i_clk) disable iff (i_rst)
        tx_st_q != aspm_pkg::ST_STOP ##1 tx_st_q == aspm_pkg::ST_STOP
        |-> ti_q && o_serial_tx_line)
        else $error("transmit flag not set at stop bit");
    rx_disabled_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !ren_q && rx_st_q == aspm_pkg::ST_IDLE |=>
        rx_st_q == aspm_pkg::ST_IDLE)
        else $error("receiver started while disabled");
    overrun_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rx_samp && rx_st_q == aspm_pkg::ST_STOP && ri_q && !ctrl_wr_any
        |=> $stable(rbuf_q) && $stable(rb8_q))
        else $error("overrun changed the receive latch");
    rx_flag_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rx_samp && rx_st_q == aspm_pkg::ST_STOP && !ri_q && !mce_q
        |=> ri_q && rbuf_q == $past(rx_sh_q))
        else $error("accepted frame not latched");
    flags_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ti_q && !ctrl_wr_any |=> ti_q ##0 o_irq == i_int_en)
        else $error("transmit flag dropped without a write");
    fixed_bit_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_sfr_rd && i_sfr_addr == aspm_pkg::CTRL_ADDR |=>
        o_sfr_rdata[aspm_pkg::FIXED_POS])
        else $error("unused control bit read as 0");

endmodule // aspm_uart

`default_nettype wire

// *** verification/aspm_remote_uart.sv ***
`timescale 1ns/10ps
`default_nettype none

module aspm_remote_uart #(
    parameter int BIT_CYC = 16
) (
    // Clock
    input  wire logic i_clk,
    // Serial lines seen from the remote end
    input  wire logic i_line,
    output logic      o_line
);
    initial o_line = 1'b1;

    // One bit time on the line, changed just after an edge
    task automatic put(input logic v);
        @(posedge i_clk);
        #1 o_line = v;
        repeat (BIT_CYC - 1) @(posedge i_clk);
    endtask

    // Start low, bits LSB first, stop, then idle high
    task automatic send(input logic [8:0] d, input int n, input logic stp);
        put(1'b0);
        for (int k = 0; k < n; k++) begin
            put(d[k]);
        end
        put(stp);
        put(1'b1);
        put(1'b1);
    endtask

    // Sample each bit at its centre, timed from the start edge
    task automatic capture(input int n, output logic [8:0] d,
                           output logic stp);
        d = 9'h000;
        @(negedge i_line);
        repeat (BIT_CYC / 2) @(posedge i_clk);
        for (int k = 0; k < n; k++) begin
            repeat (BIT_CYC) @(posedge i_clk);
            d[k] = i_line;
        end
        repeat (BIT_CYC) @(posedge i_clk);
        stp = i_line;
    endtask
endmodule // aspm_remote_uart

`default_nettype wire

// *** verification/test_async_serial_port_multiproc.sv ***
`timescale 1ns/10ps
`default_nettype none

module test_async_serial_port_multiproc;
    localparam logic [7:0] CA = aspm_pkg::CTRL_ADDR;
    localparam logic [7:0] DA = aspm_pkg::DATA_ADDR;

    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic [7:0] i_sfr_addr = 8'h00;
    logic       i_sfr_wr = 1'b0;
    logic       i_sfr_bit_wr = 1'b0;
    logic [2:0] i_sfr_bit_sel = 3'h0;
    logic [7:0] i_sfr_wdata = 8'h00;
    logic       i_sfr_rd = 1'b0;
    logic       i_int_en = 1'b0;
    logic       i_tx_ovf = 1'b0;
    logic [7:0] tmr_q = 8'h00;
    logic [7:0] o_sfr_rdata;
    logic       o_tx_ready;
    logic       o_irq;
    logic       rx_line;
    logic       tx_line;
    logic [8:0] d;
    logic       s;
    int         n_fail = 0;
    int         n_tests = 0;
    int         nw;

    // 4 ns clock
    always #2 i_clk = ~i_clk;

    // Reload timer: overflow every 8 cycles, so a bit spans 16
    always @(posedge i_clk) begin
        tmr_q <= (tmr_q == 8'hff) ? 8'hf8 : tmr_q + 8'h01;
        i_tx_ovf <= (tmr_q == 8'hff);
    end

    aspm_uart aspm_uart_i (
        .i_clk            (i_clk),
        .i_rst            (i_rst),
        .i_sfr_addr       (i_sfr_addr),
        .i_sfr_wr         (i_sfr_wr),
        .i_sfr_bit_wr     (i_sfr_bit_wr),
        .i_sfr_bit_sel    (i_sfr_bit_sel),
        .i_sfr_wdata      (i_sfr_wdata),
        .i_sfr_rd         (i_sfr_rd),
        .o_sfr_rdata      (o_sfr_rdata),
        .o_tx_ready       (o_tx_ready),
        .i_timer_en       (1'b1),
        .i_timer_tick     (1'b1),
        .i_tx_ovf         (i_tx_ovf),
        .i_baud_reload    (8'hf8),
        .i_int_en         (i_int_en),
        .o_irq            (o_irq),
        .i_serial_rx_line (rx_line),
        .o_serial_tx_line (tx_line)
    );

    aspm_remote_uart #(.BIT_CYC(16)) aspm_remote_uart_i (
        .i_clk  (i_clk),
        .i_line (tx_line),
        .o_line (rx_line)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        #1 i_sfr_addr = a;
        i_sfr_wdata = v;
        i_sfr_wr = 1'b1;
        @(posedge i_clk);
        #1 i_sfr_wr = 1'b0;
    endtask

    task automatic bitw(input logic [2:0] b, input logic v);
        @(posedge i_clk);
        #1 i_sfr_addr = CA;
        i_sfr_bit_sel = b;
        i_sfr_wdata = {7'h00, v};
        i_sfr_bit_wr = 1'b1;
        @(posedge i_clk);
        #1 i_sfr_bit_wr = 1'b0;
    endtask

    // Read data is registered, so it is taken after the read edge
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        #1 i_sfr_addr = a;
        i_sfr_rd = 1'b1;
        @(posedge i_clk);
        #1 i_sfr_rd = 1'b0;
        chk(o_sfr_rdata, exp);
    endtask

    task automatic t_reset;
        rdchk(CA, 8'h40);
        rdchk(DA, 8'h00);
        wr(CA, 8'h00);
        rdchk(CA, 8'h40);
    endtask

    // Plain 8-bit send, flag, request and software clear
    task automatic t_tx8;
        i_int_en = 1'b1;
        fork
            aspm_remote_uart_i.capture(8, d, s);
            wr(DA, 8'ha5);
        join
        chk(d[7:0], 8'ha5);
        chk({7'h00, s}, 8'h01);
        rdchk(CA, 8'h42);
        chk({7'h00, o_irq}, 8'h01);
        bitw(3'h1, 1'b0);
        chk({7'h00, o_irq}, 8'h00);
        repeat (32) @(posedge i_clk);
    endtask

    task automatic t_tx9;
        wr(CA, 8'h88);
        fork
            aspm_remote_uart_i.capture(9, d, s);
            wr(DA, 8'h3c);
        join
        chk(d[7:0], 8'h3c);
        chk({7'h00, d[8]}, 8'h01);
        chk({7'h00, s}, 8'h01);
        rdchk(CA, 8'hca);
        repeat (32) @(posedge i_clk);
        wr(CA, 8'h00);
    endtask

    // Fill the buffer once the first frame is under way, so no pop can
    // free a slot before the refused write; queued bytes leave in order
    task automatic t_buf;
        fork
            begin
                wr(DA, 8'h10);
                @(negedge tx_line);
                nw = 1;
                while (nw < 4 && o_tx_ready === 1'b1) begin
                    wr(DA, 8'h10 + 8'(nw));
                    nw++;
                end
                chk({7'h00, o_tx_ready}, 8'h00);
                wr(DA, 8'hee);
            end
            for (int k = 0; k < 3; k++) begin
                aspm_remote_uart_i.capture(8, d, s);
                chk(d[7:0], 8'h10 + 8'(k));
            end
        join
        repeat (48) @(posedge i_clk);
        chk({7'h00, tx_line}, 8'h01);
        chk(8'(nw), 8'h03);
        wr(CA, 8'h00);
    endtask

    task automatic t_rx8;
        wr(CA, 8'h10);
        aspm_remote_uart_i.send(9'h096, 8, 1'b1);
        rdchk(DA, 8'h96);
        rdchk(CA, 8'h55);
        chk({7'h00, o_irq}, 8'h01);
        aspm_remote_uart_i.send(9'h011, 8, 1'b1);
        rdchk(DA, 8'h96);
        rdchk(CA, 8'h55);
        wr(CA, 8'h00);
        aspm_remote_uart_i.send(9'h022, 8, 1'b1);
        rdchk(CA, 8'h40);
        wr(CA, 8'h30);
        aspm_remote_uart_i.send(9'h033, 8, 1'b0);
        rdchk(CA, 8'h70);
        rdchk(DA, 8'h96);
    endtask

    task automatic t_rx9;
        wr(CA, 8'hb0);
        aspm_remote_uart_i.send(9'h044, 9, 1'b1);
        rdchk(CA, 8'hf0);
        aspm_remote_uart_i.send(9'h15a, 9, 1'b1);
        rdchk(DA, 8'h5a);
        rdchk(CA, 8'hf5);
        wr(CA, 8'h90);
        aspm_remote_uart_i.send(9'h06b, 9, 1'b0);
        rdchk(DA, 8'h6b);
        rdchk(CA, 8'hd1);
    endtask

    task automatic final_report;
        if (n_fail == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge i_clk);
        #1 i_rst = 1'b0;
        t_reset();
        t_tx8();
        t_tx9();
        t_buf();
        t_rx8();
        t_rx9();
        final_report();
    end

    // Watchdog: about ten times the expected run
    initial begin
        #100000;
        n_fail++;
        final_report();
    end
endmodule // test_async_serial_port_multiproc

`default_nettype wire
